// [core/tcpp_timer.sv]
// sixteen-bit count-up timer with compare, pwm and single-pulse modes
`timescale 1ns/1ps
module tcpp_timer #(
    parameter logic [7:0] TBC_DIV = 8'hff // tick period of base-clock source, minus one
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // pins
    input wire logic ext_clock_pin_in,
    output logic timer_output_pin_out,
    output logic timer_output_pin_oe_out,
    // events
    output logic match_a_pulse_out,
    output logic match_p_pulse_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic count_pause_bit;         // counter hold
        logic [2:0] timer_clock_select; // clock source code
        logic counter_run_bit;         // counter on
        logic [1:0] mode_select;       // high, low
        logic [1:0] pin_function;      // high, low
        logic output_initial_level;    // init / active level
        logic output_invert;           // pin inversion
        logic period_duty_swap;        // pwm period/duty swap
        logic clear_source_select;     // counter clear source
        logic [15:0] compare_a_value;  // compare a
        logic [7:0] period_compare_register; // period compare
        logic [15:0] cnt;              // the counter
        logic match_a_flag;            // sticky a flag
        logic match_p_flag;            // sticky p flag
        logic run_d;                   // run bit one cycle ago
        logic ext_d;                   // pin one cycle ago
        logic [7:0] div;               // prescaler
        logic [7:0] tbc;               // base-clock divider
        logic core_out;                // unpolarised pin level
        logic [7:0] rdata;             // read data
        logic pin;                     // pin register
        logic pin_oe;                  // pin enable register
        logic pa;                      // a event pulse
        logic pp;                      // p event pulse
    } tcpp_state_t;

    tcpp_state_t s_r;
    tcpp_state_t s_nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // short names for package constants, declared ahead of every use
    localparam logic [7:0] TCPP_RST_BYTE = tcpp_pkg::TCPP_RST_BYTE;
    localparam int TCPP_FL_A = tcpp_pkg::TCPP_FL_A;
    localparam int TCPP_FL_P = tcpp_pkg::TCPP_FL_P;
    localparam int TCPP_C0_PAUSE = tcpp_pkg::TCPP_C0_PAUSE;
    localparam int TCPP_C0_CKS_LO = tcpp_pkg::TCPP_C0_CKS_LO;
    localparam int TCPP_C0_RUN = tcpp_pkg::TCPP_C0_RUN;
    localparam int TCPP_C1_MODE_LO = tcpp_pkg::TCPP_C1_MODE_LO;
    localparam int TCPP_C1_PINF_LO = tcpp_pkg::TCPP_C1_PINF_LO;
    localparam int TCPP_C1_INIT = tcpp_pkg::TCPP_C1_INIT;
    localparam int TCPP_C1_INV = tcpp_pkg::TCPP_C1_INV;
    localparam int TCPP_C1_SWAP = tcpp_pkg::TCPP_C1_SWAP;
    localparam int TCPP_C1_CCLR = tcpp_pkg::TCPP_C1_CCLR;
    // period value from the period register, zero meaning full range
    function automatic logic [16:0] tcpp_pval(input logic [7:0] p);
        tcpp_pval = (p == TCPP_RST_BYTE) ? tcpp_pkg::TCPP_FULL_PERIOD : {1'b0, p, 8'h00};
    endfunction
    // period comparator: counter top byte against register
    function automatic logic tcpp_pmatch(input logic [15:0] c, input logic [7:0] p);
        tcpp_pmatch = (p != tcpp_pkg::TCPP_RST_BYTE) && (c[15:8] == p) &&
                      (c[7:0] == tcpp_pkg::TCPP_RST_BYTE);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic tick;
        logic ext_edge;
        logic run_rise;
        logic [15:0] cinc;
        logic ovf;
        logic am;
        logic pm;
        logic pwm;
        logic spm;
        logic clr;
        logic [16:0] per;
        logic [16:0] duty;
        logic lvl;
        tick = 1'b0;
        s_nxt = s_r;
        s_nxt.pa = 1'b0;
        s_nxt.pp = 1'b0;
        s_nxt.rdata = tcpp_pkg::TCPP_RST_BYTE;
        s_nxt.run_d = s_r.counter_run_bit;
        s_nxt.ext_d = ext_clock_pin_in;
        s_nxt.div = s_r.div + 8'h01;
        s_nxt.tbc = (s_r.tbc == TBC_DIV) ? tcpp_pkg::TCPP_DIV_RST : s_r.tbc + 8'h01;
        run_rise = s_r.counter_run_bit && !s_r.run_d;
        pwm = (s_r.mode_select == tcpp_pkg::TCPP_MODE_PWM);
        spm = pwm && (s_r.pin_function == tcpp_pkg::TCPP_PF_TOG);
        // clock source selection
        unique case (s_r.timer_clock_select)
            tcpp_pkg::TCPP_CK_SYS4: tick = (s_r.div[1:0] == 2'h3);
            tcpp_pkg::TCPP_CK_SYS: tick = 1'b1;
            tcpp_pkg::TCPP_CK_H16: tick = (s_r.div[3:0] == 4'hf);
            tcpp_pkg::TCPP_CK_H64: tick = (s_r.div[5:0] == 6'h3f);
            tcpp_pkg::TCPP_CK_TBC: tick = (s_r.tbc == TBC_DIV);
            tcpp_pkg::TCPP_CK_H8: tick = (s_r.div[2:0] == 3'h7);
            tcpp_pkg::TCPP_CK_PINR: tick = ext_clock_pin_in && !s_r.ext_d;
            tcpp_pkg::TCPP_CK_PINF: tick = !ext_clock_pin_in && s_r.ext_d;
        endcase
        ext_edge = (s_r.timer_clock_select == tcpp_pkg::TCPP_CK_PINF) ?
                   (!ext_clock_pin_in && s_r.ext_d) : (ext_clock_pin_in && !s_r.ext_d);
        // count step; matches seen when the counter lands on a value
        cinc = s_r.cnt + 16'h0001;
        ovf = (s_r.cnt == 16'hffff);
        am = 1'b0;
        pm = 1'b0;
        clr = 1'b0;
        if (run_rise) begin
            s_nxt.cnt = tcpp_pkg::TCPP_RST_WORD;
        end else if (s_r.counter_run_bit && !s_r.count_pause_bit && tick) begin
            am = (cinc == s_r.compare_a_value);
            pm = tcpp_pmatch(cinc, s_r.period_compare_register) ||
                 (s_r.period_compare_register == TCPP_RST_BYTE && ovf);
            if (spm) begin
                clr = 1'b0;
            end else if (pwm) begin
                clr = s_r.period_duty_swap ? am : pm;
            end else begin
                clr = s_r.clear_source_select ? am : pm;
            end
            s_nxt.cnt = clr ? tcpp_pkg::TCPP_RST_WORD : cinc;
        end
        // flags: set wins over a software clear
        if (wr_in && addr_in == tcpp_pkg::TCPP_ADDR_FLAGS) begin
            if (wdata_in[TCPP_FL_A]) s_nxt.match_a_flag = 1'b0;
            if (wdata_in[TCPP_FL_P]) s_nxt.match_p_flag = 1'b0;
        end
        if (am) begin
            s_nxt.match_a_flag = 1'b1;
            s_nxt.pa = 1'b1;
        end
        if (pm && !spm && (pwm || !s_r.clear_source_select)) begin
            s_nxt.match_p_flag = 1'b1;
            s_nxt.pp = 1'b1;
        end
        // register writes
        if (wr_in) begin
            unique case (addr_in)
                tcpp_pkg::TCPP_ADDR_CTRL0: begin
                    s_nxt.count_pause_bit = wdata_in[TCPP_C0_PAUSE];
                    s_nxt.timer_clock_select = wdata_in[TCPP_C0_CKS_LO +: 3];
                    s_nxt.counter_run_bit = wdata_in[TCPP_C0_RUN];
                end
                tcpp_pkg::TCPP_ADDR_CTRL1: begin
                    s_nxt.mode_select = wdata_in[TCPP_C1_MODE_LO +: 2];
                    s_nxt.pin_function = wdata_in[TCPP_C1_PINF_LO +: 2];
                    s_nxt.output_initial_level = wdata_in[TCPP_C1_INIT];
                    s_nxt.output_invert = wdata_in[TCPP_C1_INV];
                    s_nxt.period_duty_swap = wdata_in[TCPP_C1_SWAP];
                    s_nxt.clear_source_select = wdata_in[TCPP_C1_CCLR];
                end
                tcpp_pkg::TCPP_ADDR_CMPA_LO: s_nxt.compare_a_value[7:0] = wdata_in;
                tcpp_pkg::TCPP_ADDR_CMPA_HI: s_nxt.compare_a_value[15:8] = wdata_in;
                tcpp_pkg::TCPP_ADDR_PERIOD: s_nxt.period_compare_register = wdata_in;
                default: ;
            endcase
        end
        // single pulse: pin edge starts, compare a stops
        if (spm && ext_edge && !s_r.counter_run_bit) begin
            s_nxt.counter_run_bit = 1'b1;
        end
        if (spm && am) begin
            s_nxt.counter_run_bit = 1'b0;
        end
        // pin logic
        per = s_r.period_duty_swap ? {1'b0, s_r.compare_a_value}
                                   : tcpp_pval(s_r.period_compare_register);
        duty = s_r.period_duty_swap ? tcpp_pval(s_r.period_compare_register)
                                    : {1'b0, s_r.compare_a_value};
        lvl = s_r.core_out;
        s_nxt.pin_oe = (s_r.mode_select != tcpp_pkg::TCPP_MODE_TMR);
        if (s_r.mode_select == tcpp_pkg::TCPP_MODE_CMP) begin
            if (run_rise) begin
                lvl = s_r.output_initial_level;
            end else if (am) begin
                unique case (s_r.pin_function)
                    tcpp_pkg::TCPP_PF_NONE: lvl = s_r.core_out;
                    tcpp_pkg::TCPP_PF_LOW: lvl = 1'b0;
                    tcpp_pkg::TCPP_PF_HIGH: lvl = 1'b1;
                    tcpp_pkg::TCPP_PF_TOG: lvl = !s_r.core_out;
                endcase
            end
            s_nxt.core_out = lvl;
            s_nxt.pin = lvl ^ s_r.output_invert;
        end else if (spm) begin
            // pulse active while running
            lvl = s_nxt.counter_run_bit;
            s_nxt.core_out = lvl;
            s_nxt.pin = (lvl ~^ s_r.output_initial_level) ^ s_r.output_invert;
        end else if (pwm) begin
            // active while counter below duty, or always when duty reaches period
            lvl = ({1'b0, s_nxt.cnt} < duty) || (duty >= per);
            if (s_r.pin_function == tcpp_pkg::TCPP_PF_NONE) lvl = 1'b0;
            if (s_r.pin_function == tcpp_pkg::TCPP_PF_LOW) lvl = 1'b1;
            s_nxt.core_out = lvl;
            s_nxt.pin = (lvl ~^ s_r.output_initial_level) ^ s_r.output_invert;
        end else begin
            s_nxt.pin = 1'b0;
        end
        // register reads, data in the following cycle
        if (rd_in) begin
            unique case (addr_in)
                tcpp_pkg::TCPP_ADDR_CTRL0:
                    s_nxt.rdata = {s_r.count_pause_bit, s_r.timer_clock_select,
                                   s_r.counter_run_bit, 3'h0};
                tcpp_pkg::TCPP_ADDR_CTRL1:
                    s_nxt.rdata = {s_r.mode_select, s_r.pin_function,
                                   s_r.output_initial_level, s_r.output_invert,
                                   s_r.period_duty_swap, s_r.clear_source_select};
                tcpp_pkg::TCPP_ADDR_CNT_LO: s_nxt.rdata = s_r.cnt[7:0];
                tcpp_pkg::TCPP_ADDR_CNT_HI: s_nxt.rdata = s_r.cnt[15:8];
                tcpp_pkg::TCPP_ADDR_CMPA_LO: s_nxt.rdata = s_r.compare_a_value[7:0];
                tcpp_pkg::TCPP_ADDR_CMPA_HI: s_nxt.rdata = s_r.compare_a_value[15:8];
                tcpp_pkg::TCPP_ADDR_PERIOD: s_nxt.rdata = s_r.period_compare_register;
                tcpp_pkg::TCPP_ADDR_FLAGS:
                    s_nxt.rdata = {6'h00, s_r.match_p_flag, s_r.match_a_flag};
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_out = s_r.rdata;
    assign timer_output_pin_out = s_r.pin;
    assign timer_output_pin_oe_out = s_r.pin_oe;
    assign match_a_pulse_out = s_r.pa;
    assign match_p_pulse_out = s_r.pp;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence run_start_s;
        !s_r.counter_run_bit ##1 s_r.counter_run_bit;
    endsequence

    run_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        run_start_s |=> (s_r.cnt == 16'h0000))
        else $error("counter not zeroed at run start");
    pause_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_r.count_pause_bit && s_r.run_d && s_r.counter_run_bit) |=> $stable(s_r.cnt))
        else $error("counter moved while paused");
    stop_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!s_r.counter_run_bit && !s_nxt.counter_run_bit) |=> $stable(s_r.cnt))
        else $error("counter moved while off");
    pflag_cclr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_r.mode_select == 2'h0 && s_r.clear_source_select) |=> !s_r.pp)
        else $error("period flag with clear select high");
    cmp_init_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_r.mode_select == 2'h0 && s_r.counter_run_bit && !s_r.run_d) |=>
        (s_r.pin == (s_r.output_initial_level ^ s_r.output_invert)))
        else $error("pin not at initial level");
    tmr_pin_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_r.mode_select == 2'h3) |=> !s_r.pin_oe)
        else $error("pin driven in timer mode");
    pulse_end_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_r.mode_select == 2'h2 && s_r.pin_function == 2'h3 && s_r.pa) |->
        !s_r.counter_run_bit)
        else $error("run bit kept after pulse match");
    aflag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_r.pa |-> s_r.match_a_flag)
        else $error("a pulse without flag");
endmodule

// [shared/tcpp_pkg.sv]
// constants for the sixteen-bit compare / pwm / single-pulse timer
//
// Function
// - period compare uses counter bits fifteen to eight
// - zero period value means full overflow period
// - clear select low: clear on period match
// - mode code 00 selects compare-match output
// - compare mode with clear select low raises both match flags
// - clear select high: clear on a, no p-flag
// - pin changes only on compare-a match or run start
// - run rising edge loads pin initial level
// - mode 11 counts like compare, pin unused
// - mode 10 with pin code 10 gives pwm
// - swap low: period from p, duty a
// - swap high: period from a, duty p
// - duty at or above period gives full
// - pwm raises both flags on their matches
// - pwm pin codes 00/01 force level, polarity
// - pwm ignores clear select, swap picks period
// - mode 10 with pin code 11 single pulse
// - external edge or software sets run bit
// - compare-a match ends pulse, clears run, flags
// - single pulse counter zeroed only at start
// - run rising zeroes counter, falling holds it
// - pause holds counter, resume from held value
// - compare pin codes: none, low, high, toggle
// - clock select: internal divides or pin edges
package tcpp_pkg;
    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [2:0] TCPP_ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] TCPP_ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] TCPP_ADDR_CNT_LO = 3'h2;
    localparam logic [2:0] TCPP_ADDR_CNT_HI = 3'h3;
    localparam logic [2:0] TCPP_ADDR_CMPA_LO = 3'h4;
    localparam logic [2:0] TCPP_ADDR_CMPA_HI = 3'h5;
    localparam logic [2:0] TCPP_ADDR_PERIOD = 3'h6;
    localparam logic [2:0] TCPP_ADDR_FLAGS = 3'h7;
    // ----------------------------------------------------------------
    // field positions in control 0 and control 1
    // ----------------------------------------------------------------
    localparam int TCPP_C0_PAUSE = 7;
    localparam int TCPP_C0_CKS_LO = 4;
    localparam int TCPP_C0_RUN = 3;
    localparam int TCPP_C1_MODE_LO = 6;
    localparam int TCPP_C1_PINF_LO = 4;
    localparam int TCPP_C1_INIT = 3;
    localparam int TCPP_C1_INV = 2;
    localparam int TCPP_C1_SWAP = 1;
    localparam int TCPP_C1_CCLR = 0;
    // flag register bits
    localparam int TCPP_FL_A = 0;
    localparam int TCPP_FL_P = 1;
    // ----------------------------------------------------------------
    // codes and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] TCPP_MODE_CMP = 2'h0;
    localparam logic [1:0] TCPP_MODE_PWM = 2'h2;
    localparam logic [1:0] TCPP_MODE_TMR = 2'h3;
    localparam logic [1:0] TCPP_PF_NONE = 2'h0;
    localparam logic [1:0] TCPP_PF_LOW = 2'h1;
    localparam logic [1:0] TCPP_PF_HIGH = 2'h2;
    localparam logic [1:0] TCPP_PF_TOG = 2'h3;
    localparam logic [2:0] TCPP_CK_SYS4 = 3'h0;
    localparam logic [2:0] TCPP_CK_SYS = 3'h1;
    localparam logic [2:0] TCPP_CK_H16 = 3'h2;
    localparam logic [2:0] TCPP_CK_H64 = 3'h3;
    localparam logic [2:0] TCPP_CK_TBC = 3'h4;
    localparam logic [2:0] TCPP_CK_H8 = 3'h5;
    localparam logic [2:0] TCPP_CK_PINR = 3'h6;
    localparam logic [2:0] TCPP_CK_PINF = 3'h7;
    localparam logic [7:0] TCPP_RST_BYTE = 8'h00;
    localparam logic [15:0] TCPP_RST_WORD = 16'h0000;
    localparam logic [16:0] TCPP_FULL_PERIOD = 17'h10000;
    localparam logic [7:0] TCPP_DIV_RST = 8'h00;
    localparam logic [7:0] TCPP_DIV_MAX = 8'hff;
endpackage

// [sim/tb_top.sv]
// self-checking bench for the compare / pwm / single-pulse timer
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // clock, reset, ports and bookkeeping
    // ------------------------------------------------------------
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic ext_pin, pin, pin_oe, pad, match_a, match_p;
    logic rd_q = 1'b0; // read data due in this cycle
    logic [7:0] exp_q[$]; // expected read data, oldest first
    int errors = 0;
    int checked = 0;
    int hi_c, a_c, p_c, e_c; // window counts: pad high, flags, pad edges
    logic [31:0] seed = 32'h2467f939;
    logic [7:0] pf_c1[3] = '{8'h08, 8'h18, 8'h20}; // pin code, initial level
    logic pf_exp[3] = '{1'b1, 1'b0, 1'b1};
    logic [7:0] pw_c1[6] = '{8'ha8, 8'hac, 8'ha8, 8'haa, 8'h88, 8'h98};
    logic [15:0] pw_a[6] = '{16'h0040, 16'h0040, 16'h0300, 16'h0100, 16'h0040, 16'h0040};
    logic [7:0] pw_p[6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01};
    int pw_hi[6] = '{256, 768, 1024, 1024, 0, 1024};
    logic [7:0] ck_c0[3] = '{8'h08, 8'h58, 8'h48}; // run on /4, /8, base clock
    int ck_p[3] = '{4, 2, 4}; // period matches per 4096 cycles
    always #12.5 clk_in = ~clk_in;

    tcpp_timer #(.TBC_DIV(8'h03)) u_dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_clock_pin_in(ext_pin),
        .timer_output_pin_out(pin), .timer_output_pin_oe_out(pin_oe),
        .match_a_pulse_out(match_a), .match_p_pulse_out(match_p));
    tcpp_pin_partner u_pin (
        .clk_in(clk_in), .pin_in(pin), .pin_oe_in(pin_oe), .ext_pin_out(ext_pin),
        .pad_out(pad));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // a read notes its expected byte; the watcher below compares it
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask
    always @(posedge clk_in) rd_q <= rd_in;
    always @(negedge clk_in) begin
        if (rd_q === 1'b1 && exp_q.size() > 0) begin
            check("read data", rdata_out, exp_q.pop_front());
        end
    end
    // stop, program, clear flags, restart on the system clock
    task automatic cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
        wr(3'h0, 8'h10);
        wr(3'h1, c1);
        wr(3'h4, a[7:0]);
        wr(3'h5, a[15:8]);
        wr(3'h6, p);
        wr(3'h7, 8'h03);
        wr(3'h0, 8'h18);
    endtask
    // count pad level, pad edges and flag pulses over n cycles
    task automatic window(input int n);
        logic prev;
        hi_c = 0;
        a_c = 0;
        p_c = 0;
        e_c = 0;
        @(negedge clk_in);
        prev = pad;
        repeat (n) begin
            @(negedge clk_in);
            hi_c += int'(pad);
            a_c += int'(match_a);
            p_c += int'(match_p);
            e_c += int'(pad !== prev);
            prev = pad;
        end
    endtask
    // a hang is cut short here
    initial begin
        repeat (60000) @(posedge clk_in);
        errors++;
        test_done();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
        repeat (4) begin
            seed = xs(seed);
            wr(3'h4, seed[7:0] | 8'h01);
            wr(3'h6, seed[23:16]);
            rd(3'h4, seed[7:0] | 8'h01);
            rd(3'h6, seed[23:16]);
        end
        // counting external edges, pause, hold and restart
        wr(3'h4, 8'hff);
        wr(3'h5, 8'hff);
        wr(3'h6, 8'h00);
        wr(3'h0, 8'h68);
        u_pin.pulse(5, 6);
        rd(3'h2, 8'h05);
        wr(3'h0, 8'he8);
        u_pin.pulse(3, 12);
        rd(3'h2, 8'h05);
        wr(3'h0, 8'h68);
        u_pin.pulse(2, 6);
        rd(3'h2, 8'h07);
        wr(3'h0, 8'h78);
        u_pin.pulse(4, 6);
        rd(3'h2, 8'h0b);
        wr(3'h0, 8'h70);
        u_pin.pulse(3, 6);
        rd(3'h2, 8'h0b);
        wr(3'h0, 8'h78);
        u_pin.pulse(1, 6);
        rd(3'h2, 8'h01);
        rd(3'h3, 8'h00);
        // compare mode, toggle on a, clear on p
        cfg(8'h38, 16'h0080, 8'h01);
        repeat (4) @(posedge clk_in);
        check("initial level", pad, 1'b1);
        window(2048);
        check("p matches", p_c, 8);
        check("a matches", a_c, 8);
        check("pin toggles", e_c, 8);
        wr(3'h0, 8'h10);
        rd(3'h7, 8'h03);
        wr(3'h7, 8'h03);
        rd(3'h7, 8'h00);
        for (int i = 0; i < 3; i++) begin
            cfg(pf_c1[i], 16'h0080, 8'h01);
            window(600);
            check("pin code level", pad, pf_exp[i]);
        end
        // clear on a: p flag never raised
        cfg(8'h39, 16'h0200, 8'h01);
        window(300);
        window(4096);
        check("p under clear a", p_c, 0);
        check("a under clear a", a_c, 8);
        // timer mode leaves the pin alone
        cfg(8'hc0, 16'h0080, 8'h01);
        window(300);
        window(2048);
        check("timer p", p_c, 8);
        check("timer pin enable", pin_oe, 1'b0);
        // divided clocks: period of 256 ticks, counter left running
        for (int i = 0; i < 3; i++) begin
            wr(3'h0, ck_c0[i]);
            window(300);
            window(4096);
            check("divided clock p", p_c, ck_p[i]);
        end
        // pwm duty, polarity, full duty, swap and forced levels
        for (int i = 0; i < 6; i++) begin
            cfg(pw_c1[i], pw_a[i], pw_p[i]);
            window(300);
            window(1024);
            check("pwm high time", hi_c, pw_hi[i]);
            if (i == 0) begin
                check("pwm a flags", a_c, 4);
                check("pwm p flags", p_c, 4);
            end
        end
        // single pulse by pin edge, then by software
        wr(3'h0, 8'h10);
        wr(3'h1, 8'hb8);
        wr(3'h4, 8'h40);
        wr(3'h5, 8'h00);
        fork
            window(400);
            u_pin.pulse(1, 6);
        join
        check("pin pulse width", (hi_c >= 62 && hi_c <= 66), 1'b1);
        check("pin pulse flag", a_c, 1);
        rd(3'h0, 8'h10);
        wr(3'h0, 8'h18);
        window(400);
        check("soft pulse width", (hi_c >= 62 && hi_c <= 66), 1'b1);
        rd(3'h0, 8'h10);
        wr(3'h5, 8'h04);
        wr(3'h0, 8'h18);
        repeat (50) @(posedge clk_in);
        check("pulse running", pad, 1'b1);
        wr(3'h0, 8'h10);
        repeat (4) @(posedge clk_in);
        check("soft end", pad, 1'b0);
        repeat (4) @(posedge clk_in);
        check("pending reads", exp_q.size(), 0);
        test_done();
    end
endmodule

// [sim/tcpp_pin_partner.sv]
// partner model: drives the external clock pin and resolves the output pad
`timescale 1ns/1ps
module tcpp_pin_partner (
    // clock
    input wire logic clk_in,
    // output pin from the timer
    input wire logic pin_in,
    input wire logic pin_oe_in,
    // trigger pin to the timer and resolved pad level
    output logic ext_pin_out,
    output logic pad_out
);
    // ------------------------------------------------------------
    // pad: a released pin never shows a stale level
    // ------------------------------------------------------------
    logic last_r = 1'b0; // last level driven on the pad
    always @(posedge clk_in) begin
        // released: hold the last driven level, the pad shows its inverse
        if (pin_oe_in) begin
            last_r <= pin_in;
        end
    end
    assign pad_out = pin_oe_in ? pin_in : ~last_r;
    // ------------------------------------------------------------
    // edges on the external pin, width w sets prompt or slow
    // ------------------------------------------------------------
    initial ext_pin_out = 1'b0;
    task automatic pulse(input int n, input int w);
        repeat (n) begin
            @(posedge clk_in);
            ext_pin_out <= 1'b1;
            repeat (w) @(posedge clk_in);
            ext_pin_out <= 1'b0;
            repeat (w) @(posedge clk_in);
        end
    endtask
endmodule
